// File: hw/pit_pkg.sv
// package: register map, reset values and carriers of the interval timer
package pit_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the apb bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFF_COUNT  = 8'h00;
  localparam logic [7:0]  OFF_SCALE  = 8'h04;
  localparam logic [7:0]  OFF_PERIOD = 8'h08;
  localparam logic [7:0]  OFF_CTRL   = 8'h0c;
  localparam logic [7:0]  OFF_STAT   = 8'h10;
  localparam logic [7:0]  OFF_MASK   = 8'h14;

  // ----------------------------------------------------------------
  // widths, field positions, reset values
  // ----------------------------------------------------------------
  localparam int          COUNT_W    = 16;
  localparam int          SCALE_W    = 8;
  localparam int          IRQ_W      = 1;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          IRQ_ZERO_BIT = 0;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [7:0]  SCALE_RST  = 8'h00;
  localparam logic        EN_RST     = 1'h0;
  localparam logic [0:0]  IRQ_RST    = 1'h0;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [7:0]  SCALE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        enable;
    logic [7:0]  scale;
    logic [15:0] period;
  } pit_cfg_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pit_apb_req_t;

endpackage : pit_pkg

// File: hw/pit_prescaler.sv
// prescaler: one tick every scale+1 processor cycles while enabled
`timescale 1ns/1ps
module pit_prescaler (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       enable_in,
  input  wire logic [7:0] scale_in,
  // tick
  output logic            tick_out
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // a new scale takes effect at the next reload, so a write never
  // stretches or cuts the interval that is already running
  always_comb begin
    if (!enable_in) begin
      cnt_next = scale_in;
    end else if (cnt_reg == pit_pkg::SCALE_ZERO) begin
      cnt_next = scale_in;
    end else begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= pit_pkg::SCALE_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_out = enable_in && (cnt_reg == pit_pkg::SCALE_ZERO);

endmodule : pit_prescaler

// File: hw/pit_irq.sv
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module pit_irq (
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // events and software access
  input  wire logic [pit_pkg::IRQ_W-1:0] evt_in,
  input  wire logic                    stat_wr_in,
  input  wire logic                    mask_wr_in,
  input  wire logic [pit_pkg::IRQ_W-1:0] wdata_in,
  // state
  output logic [pit_pkg::IRQ_W-1:0]    status_out,
  output logic [pit_pkg::IRQ_W-1:0]    mask_out,
  output logic                         irq_out
);

  logic [pit_pkg::IRQ_W-1:0] stat_reg;
  logic [pit_pkg::IRQ_W-1:0] stat_next;
  logic [pit_pkg::IRQ_W-1:0] mask_reg;
  logic [pit_pkg::IRQ_W-1:0] mask_next;

  // set wins over clear so an event in the clearing cycle is kept
  for (genvar i = 0; i < pit_pkg::IRQ_W; i++) begin : g_bit
    always_comb begin
      stat_next[i] = evt_in[i] ||
                     (stat_reg[i] && !(stat_wr_in && wdata_in[i]));
      mask_next[i] = mask_wr_in ? wdata_in[i] : mask_reg[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_reg <= pit_pkg::IRQ_RST;
      mask_reg <= pit_pkg::IRQ_RST;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign status_out = stat_reg;
  assign mask_out   = mask_reg;
  assign irq_out    = |(stat_reg & mask_reg);

endmodule : pit_irq

// File: hw/pit_timer.sv
// top: apb register file, 16-bit down-counter and reload of the timer
`timescale 1ns/1ps
module pit_timer (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // interrupt and event
  output logic             irq_out,
  output logic             zero_evt_out
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  pit_pkg::pit_apb_req_t req;
  logic                  addr_hit;
  logic                  access;
  logic                  wr;
  logic                  wr_count;
  logic                  wr_scale;
  logic                  wr_period;
  logic                  wr_ctrl;
  logic                  wr_stat;
  logic                  wr_mask;

  assign req.sel    = psel_in;
  assign req.enable = penable_in;
  assign req.write  = pwrite_in;
  assign req.addr   = paddr_in;
  assign req.wdata  = pwdata_in;

  always_comb begin
    case (req.addr)
      pit_pkg::OFF_COUNT,
      pit_pkg::OFF_SCALE,
      pit_pkg::OFF_PERIOD,
      pit_pkg::OFF_CTRL,
      pit_pkg::OFF_STAT,
      pit_pkg::OFF_MASK: addr_hit = 1'b1;
      default:           addr_hit = 1'b0;
    endcase
  end

  // zero-wait slave: every access phase completes in its first cycle
  assign access      = req.sel && req.enable;
  assign wr          = access && req.write && addr_hit;
  assign wr_count    = wr && (req.addr == pit_pkg::OFF_COUNT);
  assign wr_scale    = wr && (req.addr == pit_pkg::OFF_SCALE);
  assign wr_period   = wr && (req.addr == pit_pkg::OFF_PERIOD);
  assign wr_ctrl     = wr && (req.addr == pit_pkg::OFF_CTRL);
  assign wr_stat     = wr && (req.addr == pit_pkg::OFF_STAT);
  assign wr_mask     = wr && (req.addr == pit_pkg::OFF_MASK);
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !addr_hit;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  pit_pkg::pit_cfg_t cfg_reg;
  pit_pkg::pit_cfg_t cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_scale) begin
      cfg_next.scale = req.wdata[7:0];
    end
    if (wr_period) begin
      cfg_next.period = req.wdata[15:0];
    end
    if (wr_ctrl) begin
      cfg_next.enable = req.wdata[pit_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg.enable <= pit_pkg::EN_RST;
      cfg_reg.scale  <= pit_pkg::SCALE_RST;
      cfg_reg.period <= pit_pkg::PERIOD_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic tick;

  pit_prescaler u_prescaler (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .enable_in (cfg_reg.enable),
    .scale_in  (cfg_reg.scale),
    .tick_out  (tick)
  );

  // ----------------------------------------------------------------
  // down-counter and reload
  // ----------------------------------------------------------------
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        zero_hit;

  // a count of one is the last step: the decrement lands on zero,
  // so the reload happens in that same step and zero is never held;
  // a count already at zero (reset, software write) reloads likewise
  assign zero_hit = tick && !wr_count &&
                    (count_reg <= pit_pkg::COUNT_ONE);

  always_comb begin
    if (wr_count) begin
      count_next = req.wdata[15:0];
    end else if (zero_hit) begin
      count_next = cfg_reg.period;
    end else if (tick) begin
      count_next = count_reg - pit_pkg::COUNT_ONE;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= pit_pkg::COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign zero_evt_out = zero_hit;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [pit_pkg::IRQ_W-1:0] evt_vec;
  logic [pit_pkg::IRQ_W-1:0] stat_vec;
  logic [pit_pkg::IRQ_W-1:0] mask_vec;

  always_comb begin
    evt_vec = '0;
    evt_vec[pit_pkg::IRQ_ZERO_BIT] = zero_hit;
  end

  pit_irq u_irq (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .evt_in     (evt_vec),
    .stat_wr_in (wr_stat),
    .mask_wr_in (wr_mask),
    .wdata_in   (req.wdata[pit_pkg::IRQ_W-1:0]),
    .status_out (stat_vec),
    .mask_out   (mask_vec),
    .irq_out    (irq_out)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // captured in the setup cycle so the data output is a flip-flop
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req.addr)
      pit_pkg::OFF_COUNT:  rd_mux[15:0] = count_reg;
      pit_pkg::OFF_SCALE:  rd_mux[7:0]  = cfg_reg.scale;
      pit_pkg::OFF_PERIOD: rd_mux[15:0] = cfg_reg.period;
      pit_pkg::OFF_CTRL:   rd_mux[pit_pkg::CTRL_EN_BIT] = cfg_reg.enable;
      pit_pkg::OFF_STAT:   rd_mux[pit_pkg::IRQ_W-1:0] = stat_vec;
      pit_pkg::OFF_MASK:   rd_mux[pit_pkg::IRQ_W-1:0] = mask_vec;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    if (req.sel && !req.enable && !req.write) begin
      prdata_next = rd_mux;
    end else begin
      prdata_next = prdata_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_out = prdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // gap counter: cycles since the last tick, valid while the scale
  // and the enable have stayed steady over the whole interval
  logic [8:0] gap_reg;
  logic [8:0] gap_next;
  logic       steady_reg;
  logic       steady_next;

  always_comb begin
    gap_next    = tick ? 9'h001 : gap_reg + 9'h001;
    steady_next = tick ? 1'b1 : steady_reg;
    if (wr_scale || !cfg_reg.enable) begin
      steady_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_reg    <= 9'h000;
      steady_reg <= 1'b0;
    end else begin
      gap_reg    <= gap_next;
      steady_reg <= steady_next;
    end
  end

  sequence s_plain_step;
    tick && !wr_count && (count_reg > pit_pkg::COUNT_ONE);
  endsequence

  sequence s_zero_step;
    zero_hit;
  endsequence

  a_count_decrement: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_plain_step |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not drop by one on a tick");

  a_count_idle_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (!tick && !wr_count) |=> $stable(count_reg))
    else $error("counter moved without a tick");

  a_prescale_gap: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick && steady_reg) |-> gap_reg == {1'b0, cfg_reg.scale} + 9'h001)
    else $error("tick spacing differs from scale plus one");

  a_zero_status: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_zero_step |=> stat_vec[pit_pkg::IRQ_ZERO_BIT])
    else $error("zero reached without status set");

  a_irq_level: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_zero_step ##1 mask_vec[pit_pkg::IRQ_ZERO_BIT]) |-> irq_out)
    else $error("unmasked zero event did not raise interrupt");

  a_zero_reload: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_zero_step |=> count_reg == $past(cfg_reg.period))
    else $error("counter not reloaded from period at zero");

  a_period_no_touch: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_period && !tick && !wr_count) |=> count_reg == $past(count_reg))
    else $error("period write disturbed running count");

  // a clear that meets a zero event loses, so it is left out here
  sequence s_stat_clear;
    wr_stat && req.wdata[pit_pkg::IRQ_ZERO_BIT] && !zero_hit;
  endsequence

  a_status_sticky: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (stat_vec[pit_pkg::IRQ_ZERO_BIT] && !wr_stat) |=>
      stat_vec[pit_pkg::IRQ_ZERO_BIT])
    else $error("zero status dropped without a clear");

  a_status_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_stat_clear |=> !stat_vec[pit_pkg::IRQ_ZERO_BIT])
    else $error("writing one did not clear zero status");

  a_count_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_count |=> count_reg == $past(req.wdata[15:0]))
    else $error("count write did not land");

  a_period_kept: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !wr_period |=> $stable(cfg_reg.period))
    else $error("reload period changed without a write");

endmodule : pit_timer

// File: verification/tb_top.sv
// testbench: apb stimulus and self-checks of the prescaled interval timer
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_in;
  logic        rst_n_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic        zero_evt_out;
  int          n_mismatch;
  int          compares;
  int          cyc;
  int          seed;
  int          e1;
  int          e2;
  int          e3;
  int          s;
  int          p;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  offs [6];

  pit_timer dut (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .psel_in      (psel_in),
    .penable_in   (penable_in),
    .pwrite_in    (pwrite_in),
    .paddr_in     (paddr_in),
    .pwdata_in    (pwdata_in),
    .prdata_out   (prdata_out),
    .pready_out   (pready_out),
    .pslverr_out  (pslverr_out),
    .irq_out      (irq_out),
    .zero_evt_out (zero_evt_out)
  );

  // ----------------------------------------------------------------
  // clock, timeout
  // ----------------------------------------------------------------
  always #5 clk_in = ~clk_in;

  // longest run is well under two thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // no wait count is assumed; only the bench timeout ends a hang
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic wait_evt(output int t);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk_in);
      #1;
      if (zero_evt_out === 1'b1) break;
    end
    check("event seen", {31'h0, zero_evt_out}, 32'h1);
    t = cyc;
  endtask : wait_evt

  // cycles between two reload events for period p and scale s
  function automatic logic [31:0] exp_gap(input int pp, input int ss);
    return 32'(pp * (ss + 1));
  endfunction : exp_gap

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0; rst_n_in = 1'b0; psel_in = 1'b0; penable_in = 1'b0;
    pwrite_in = 1'b0; paddr_in = 8'h00; pwdata_in = 32'h0;
    n_mismatch = 0; compares = 0; cyc = 0; seed = 81540;
    offs = '{pit_pkg::OFF_COUNT, pit_pkg::OFF_SCALE, pit_pkg::OFF_PERIOD,
             pit_pkg::OFF_CTRL, pit_pkg::OFF_STAT, pit_pkg::OFF_MASK};
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0, rd, er);
      check("reset value", rd, 32'h0);
      check("reset err", {31'h0, er}, 32'h0);
      check("ready", {31'h0, pready_out}, 32'h1);
    end
    // unmapped place: refused both ways
    apb(1'b1, 8'h18, 32'hffffffff, rd, er);
    check("unmapped wr err", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    check("unmapped rd", rd, 32'h0);
    check("unmapped rd err", {31'h0, er}, 32'h1);
    // field widths while stopped
    wr(pit_pkg::OFF_COUNT, 32'hffffffff);
    apb(1'b0, pit_pkg::OFF_COUNT, 32'h0, rd, er);
    check("count width", rd, 32'h0000ffff);
    wr(pit_pkg::OFF_SCALE, 32'hffffffff);
    apb(1'b0, pit_pkg::OFF_SCALE, 32'h0, rd, er);
    check("scale width", rd, 32'h000000ff);
    wr(pit_pkg::OFF_PERIOD, 32'hffffffff);
    apb(1'b0, pit_pkg::OFF_PERIOD, 32'h0, rd, er);
    check("period width", rd, 32'h0000ffff);
    // corner cases first, then random scale and period
    for (int i = 0; i < 6; i++) begin
      if (i == 0) begin
        s = 0; p = 1;
      end else if (i == 1) begin
        s = 255; p = 2;
      end else begin
        s = $random(seed) & 7;
        p = ($random(seed) & 7) + 1;
      end
      wr(pit_pkg::OFF_SCALE, 32'(s));
      wr(pit_pkg::OFF_PERIOD, 32'(p));
      wr(pit_pkg::OFF_COUNT, 32'h0);
      wr(pit_pkg::OFF_MASK, 32'(i & 1));
      wr(pit_pkg::OFF_CTRL, 32'h1);
      wait_evt(e1);
      wait_evt(e2);
      check("event gap", 32'(e2 - e1), exp_gap(p, s));
      wr(pit_pkg::OFF_CTRL, 32'h0);
      apb(1'b0, pit_pkg::OFF_STAT, 32'h0, rd, er);
      check("zero status", rd, 32'h1);
      check("irq level", {31'h0, irq_out}, 32'(i & 1));
      wr(pit_pkg::OFF_STAT, 32'h1);
    end
    wr(pit_pkg::OFF_MASK, 32'h0);
    // new period waits for the next reload
    wr(pit_pkg::OFF_SCALE, 32'h1);
    wr(pit_pkg::OFF_PERIOD, 32'h5);
    wr(pit_pkg::OFF_COUNT, 32'h0);
    wr(pit_pkg::OFF_CTRL, 32'h1);
    wait_evt(e1);
    wr(pit_pkg::OFF_PERIOD, 32'h3);
    wait_evt(e2);
    wait_evt(e3);
    check("old period gap", 32'(e2 - e1), exp_gap(5, 1));
    check("new period gap", 32'(e3 - e2), exp_gap(3, 1));
    wr(pit_pkg::OFF_CTRL, 32'h0);
    // interrupt: masked, raised, cleared
    #1;
    check("irq masked", {31'h0, irq_out}, 32'h0);
    wr(pit_pkg::OFF_MASK, 32'h1);
    #1;
    check("irq raised", {31'h0, irq_out}, 32'h1);
    wr(pit_pkg::OFF_STAT, 32'h1);
    #1;
    check("irq cleared", {31'h0, irq_out}, 32'h0);
    apb(1'b0, pit_pkg::OFF_STAT, 32'h0, rd, er);
    check("status cleared", rd, 32'h0);
    stop_test();
  end
endmodule : tb_top
